// ---- logic/ees_eeprom.sv ----
// Two-wire serial memory slave with page buffer, write cycle and commit FIFO

module ees_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      cnt_ff;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data  = mem_ff[rd_ptr_ff];

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end
        else
        begin
            wr_ptr_ff <= push ? AW'((wr_ptr_ff + 1'b1) % DEPTH) : wr_ptr_ff;
            rd_ptr_ff <= pop ? AW'((rd_ptr_ff + 1'b1) % DEPTH) : rd_ptr_ff;
            cnt_ff    <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Contract
// - Respond only when slave address high nibble is 1010.
// - Next three bits match select pins or carry upper address bits per density.
// - Address LSB one means read, zero means write.
// - Acknowledge a matching slave address by pulling data low on ninth clock.
// - In writes, acknowledge memory address and every data byte on ninth clock.
// - In reads, send byte, release on ninth clock, continue while master acknowledges.
// - Byte write: address, memory address into pointer, one data byte, all acknowledged.
// - STOP after acknowledged data starts write cycle; ignore everything until done.
// - Page write takes up to sixteen bytes, committed in one write cycle.
// - Each written byte bumps only the low four pointer bits.
// - Beyond sixteen bytes the page offset wraps and overwrites buffered bytes.
// - Busy: write address not acknowledged; done: acknowledged again.
// - Write-protect high blocks all writes; low has no effect.
// - Protect pin sampled on fall before first data byte; high means no acknowledge.
// - Memory starts fully erased, every byte FFh.
// - Read address: acknowledge and send byte at current pointer at once.
// - No acknowledge then STOP returns the device to standby.
// - Random read: dummy write of address, repeated START, read address.
// - Sequential read increments across whole memory and wraps at its end.
// - Smallest density: sequential read counter does not wrap at end.
// - START is data falling while clock high; nothing answered without it.
// - STOP is data rising while clock high; it ends every command.
// - Sample data on clock rise, change output after clock fall, open drain.
module ees_eeprom #(
    parameter int ADDR_W    = 11,
    parameter int WR_CYCLES = ees_pkg::WR_TIME_MS * ees_pkg::NS_PER_MS / ees_pkg::CLK_PERIOD_NS
) (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_scl,
    input  wire logic i_sda,
    output logic      o_sda,
    output logic      o_sda_oe_n,
    input  wire logic i_write_protect,
    input  wire logic i_chip_select_pin_0,
    input  wire logic i_chip_select_pin_1,
    input  wire logic i_chip_select_pin_2,
    output logic      o_busy
);
    localparam int MEM_BYTES = 2 ** ADDR_W;
    localparam int WR_W      = $bits(ees_pkg::ees_wr_s);

    // Two flops on every pin; third stage only for edge detection of the second
    logic [2:0] scl_ff;
    logic [2:0] sda_ff;
    logic [1:0] wp_ff;
    logic [2:0] cs_s1_ff;
    logic [2:0] cs_ff;

    ees_pkg::ees_state_e st_ff;
    ees_pkg::ees_state_e nxt_st;
    logic [3:0]          cnt_ff;
    logic [3:0]          nxt_cnt;
    logic [7:0]          sh_ff;
    logic [7:0]          nxt_sh;
    logic                drv_ff;
    logic                nxt_drv;
    logic                is_rd_ff;
    logic                nxt_is_rd;
    logic [2:0]          upper_ff;
    logic [2:0]          nxt_upper;
    logic [ADDR_W-1:0]   ptr_ff;
    logic [ADDR_W-1:0]   nxt_ptr;
    logic                wp_lock_ff;
    logic                nxt_wp_lock;
    logic                pg_we;
    logic                commit;

    logic [7:0]              mem [MEM_BYTES] = '{default: ees_pkg::ERASED_BYTE};
    logic [7:0]              pg_data_ff [ees_pkg::PAGE_BYTES];
    logic [15:0]             pg_valid_ff;
    logic [ADDR_W-1:0]       cm_base_ff;
    logic                    busy_ff;
    logic [31:0]             tmr_ff;
    logic [4:0]              idx_ff;
    logic [1:0]              div_ff;
    ees_pkg::ees_wr_s        push_ent;
    ees_pkg::ees_wr_s        pop_ent;
    logic                    push_rdy;
    logic                    pop_vld;

    function automatic logic dev_hit(input logic [7:0] b, input logic [2:0] pins);
        logic ok;
        ok = (b[7:4] == ees_pkg::DEV_TYPE);
        if (ADDR_W <= 8)
        begin
            ok = ok && (b[3:1] == pins);
        end
        else if (ADDR_W == 9)
        begin
            ok = ok && (b[3:2] == pins[2:1]);
        end
        else if (ADDR_W == 10)
        begin
            ok = ok && (b[3] == pins[2]);
        end
        return ok;
    endfunction

    function automatic logic [2:0] upper_of(input logic [7:0] b);
        logic [2:0] u;
        u = 3'h0;
        if (ADDR_W == 9)
        begin
            u = {2'h0, b[1]};
        end
        else if (ADDR_W == 10)
        begin
            u = {1'h0, b[2:1]};
        end
        else if (ADDR_W >= 11)
        begin
            u = b[3:1];
        end
        return u;
    endfunction

    function automatic logic [ADDR_W-1:0] rd_next(input logic [ADDR_W-1:0] p);
        logic [ADDR_W-1:0] n;
        n = p + 1'b1;
        if (ADDR_W == 7 && p == '1)
        begin
            n = p;
        end
        return n;
    endfunction

    wire scl_hi   = scl_ff[1] && scl_ff[2];
    wire scl_rise = scl_ff[1] && !scl_ff[2];
    wire scl_fall = !scl_ff[1] && scl_ff[2];
    wire start_ev = scl_hi && sda_ff[2] && !sda_ff[1];
    wire stop_ev  = scl_hi && !sda_ff[2] && sda_ff[1];
    wire sda_in   = sda_ff[1];
    wire wp_in    = wp_ff[1];
    wire byte_end = scl_fall && (cnt_ff == ees_pkg::BITS_PER_BYTE);
    wire [7:0] rd_byte = mem[ptr_ff];
    wire [10:0] full_addr = {upper_ff, sh_ff};
    wire [ADDR_W-1:0] wr_ptr_inc = {ptr_ff[ADDR_W-1:4], ptr_ff[3:0] + 4'h1};
    wire pg_any   = (pg_valid_ff != 16'h0000);
    wire seq_done = (idx_ff == ees_pkg::PG_IDX_END);
    wire cur_vld  = !seq_done && pg_valid_ff[idx_ff[3:0]];
    wire drain_en = (div_ff == 2'(ees_pkg::DRAIN_DIV - 1));
    wire drain    = pop_vld && drain_en;
    wire wr_done  = busy_ff && (tmr_ff == 32'h0000_0000) && seq_done && !pop_vld;

    assign o_sda      = 1'b0;
    assign o_sda_oe_n = !drv_ff;
    assign o_busy     = busy_ff;
    assign push_ent   = '{addr: ees_pkg::MAX_ADDR_W'({cm_base_ff[ADDR_W-1:4], idx_ff[3:0]}),
                          data: pg_data_ff[idx_ff[3:0]]};

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            scl_ff   <= 3'h7;
            sda_ff   <= 3'h7;
            wp_ff    <= 2'h0;
            cs_s1_ff <= 3'h0;
            cs_ff    <= 3'h0;
        end
        else
        begin
            scl_ff   <= {scl_ff[1:0], i_scl};
            sda_ff   <= {sda_ff[1:0], i_sda};
            wp_ff    <= {wp_ff[0], i_write_protect};
            cs_s1_ff <= {i_chip_select_pin_2, i_chip_select_pin_1, i_chip_select_pin_0};
            cs_ff    <= cs_s1_ff;
        end
    end

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_cnt     = cnt_ff;
        nxt_sh      = sh_ff;
        nxt_drv     = drv_ff;
        nxt_is_rd   = is_rd_ff;
        nxt_upper   = upper_ff;
        nxt_ptr     = ptr_ff;
        nxt_wp_lock = wp_lock_ff;
        pg_we       = 1'b0;
        commit      = 1'b0;
        if (stop_ev)
        begin
            nxt_st  = ees_pkg::ST_IDLE;
            nxt_drv = 1'b0;
            nxt_cnt = 4'h0;
            commit  = !busy_ff && pg_any && !wp_lock_ff;
        end
        else if (start_ev)
        begin
            // While the write cycle runs a START is simply not answered
            nxt_st  = busy_ff ? ees_pkg::ST_IDLE : ees_pkg::ST_DEV;
            nxt_drv = 1'b0;
            nxt_cnt = 4'h0;
        end
        else
        begin
            case (st_ff)
                ees_pkg::ST_DEV, ees_pkg::ST_MEM, ees_pkg::ST_WR:
                begin
                    if (scl_rise && cnt_ff != ees_pkg::BITS_PER_BYTE)
                    begin
                        nxt_sh  = {sh_ff[6:0], sda_in};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_drv = 1'b1;
                        if (st_ff == ees_pkg::ST_DEV)
                        begin
                            nxt_is_rd = sh_ff[0];
                            nxt_upper = sh_ff[0] ? upper_ff : upper_of(sh_ff);
                            nxt_st    = ees_pkg::ST_DEV_ACK;
                            if (!dev_hit(sh_ff, cs_ff))
                            begin
                                nxt_drv = 1'b0;
                                nxt_st  = ees_pkg::ST_SKIP;
                            end
                        end
                        else if (st_ff == ees_pkg::ST_MEM)
                        begin
                            nxt_ptr = full_addr[ADDR_W-1:0];
                            nxt_st  = ees_pkg::ST_MEM_ACK;
                        end
                        else if (wp_lock_ff)
                        begin
                            nxt_drv = 1'b0;
                            nxt_st  = ees_pkg::ST_SKIP;
                        end
                        else
                        begin
                            pg_we   = 1'b1;
                            nxt_ptr = wr_ptr_inc;
                            nxt_st  = ees_pkg::ST_WR_ACK;
                        end
                    end
                end
                ees_pkg::ST_DEV_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_drv = 1'b0;
                        nxt_st  = ees_pkg::ST_MEM;
                        if (is_rd_ff)
                        begin
                            nxt_sh  = rd_byte;
                            nxt_drv = !rd_byte[7];
                            nxt_ptr = rd_next(ptr_ff);
                            nxt_st  = ees_pkg::ST_RD;
                        end
                    end
                end
                ees_pkg::ST_MEM_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_drv     = 1'b0;
                        nxt_wp_lock = wp_in;
                        nxt_st      = ees_pkg::ST_WR;
                    end
                end
                ees_pkg::ST_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        nxt_drv = 1'b0;
                        nxt_st  = ees_pkg::ST_WR;
                    end
                end
                ees_pkg::ST_RD:
                begin
                    if (scl_fall)
                    begin
                        nxt_cnt = cnt_ff + 4'h1;
                        nxt_sh  = {sh_ff[6:0], 1'b1};
                        nxt_drv = !sh_ff[6];
                        if (cnt_ff == ees_pkg::BIT_LAST)
                        begin
                            nxt_drv = 1'b0;
                            nxt_st  = ees_pkg::ST_RD_ACK;
                        end
                    end
                end
                ees_pkg::ST_RD_ACK:
                begin
                    if (scl_rise && sda_in)
                    begin
                        nxt_st = ees_pkg::ST_SKIP;
                    end
                    else if (scl_fall)
                    begin
                        nxt_cnt = 4'h0;
                        nxt_sh  = rd_byte;
                        nxt_drv = !rd_byte[7];
                        nxt_ptr = rd_next(ptr_ff);
                        nxt_st  = ees_pkg::ST_RD;
                    end
                end
                ees_pkg::ST_IDLE, ees_pkg::ST_SKIP:
                begin
                    nxt_drv = 1'b0;
                end
                default:
                begin
                    nxt_st  = ees_pkg::ST_IDLE;
                    nxt_drv = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_ff      <= ees_pkg::ST_IDLE;
            cnt_ff     <= 4'h0;
            sh_ff      <= 8'h00;
            drv_ff     <= 1'b0;
            is_rd_ff   <= 1'b0;
            upper_ff   <= 3'h0;
            ptr_ff     <= ees_pkg::PTR_RST[ADDR_W-1:0];
            wp_lock_ff <= 1'b0;
        end
        else
        begin
            st_ff      <= nxt_st;
            cnt_ff     <= nxt_cnt;
            sh_ff      <= nxt_sh;
            drv_ff     <= nxt_drv;
            is_rd_ff   <= nxt_is_rd;
            upper_ff   <= nxt_upper;
            ptr_ff     <= nxt_ptr;
            wp_lock_ff <= nxt_wp_lock;
        end
    end

    // Page buffer; later bytes at the same offset replace earlier ones
    always_ff @(posedge i_clk)
    begin
        if (pg_we)
        begin
            pg_data_ff[ptr_ff[3:0]] <= sh_ff;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || wr_done || (start_ev && !busy_ff))
        begin
            pg_valid_ff <= 16'h0000;
        end
        else if (pg_we)
        begin
            pg_valid_ff[ptr_ff[3:0]] <= 1'b1;
        end
    end

    // Write cycle: timer sets the minimum length, FIFO drain may extend it
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            busy_ff    <= 1'b0;
            tmr_ff     <= 32'h0000_0000;
            idx_ff     <= ees_pkg::PG_IDX_END;
            cm_base_ff <= '0;
            div_ff     <= 2'h0;
        end
        else
        begin
            div_ff <= div_ff + 2'h1;
            if (commit)
            begin
                busy_ff    <= 1'b1;
                tmr_ff     <= 32'(WR_CYCLES - 1);
                idx_ff     <= 5'h00;
                cm_base_ff <= ptr_ff;
            end
            else
            begin
                busy_ff <= busy_ff && !wr_done;
                tmr_ff  <= (tmr_ff != 32'h0000_0000) ? tmr_ff - 32'h0000_0001 : tmr_ff;
                if (!seq_done && (!cur_vld || push_rdy))
                begin
                    idx_ff <= idx_ff + 5'h01;
                end
            end
        end
    end

    ees_fifo #(
        .WIDTH (WR_W),
        .DEPTH (ees_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (cur_vld),
        .o_in_ready  (push_rdy),
        .i_in_data   (push_ent),
        .o_out_valid (pop_vld),
        .i_out_ready (drain_en),
        .o_out_data  (pop_ent)
    );

    always_ff @(posedge i_clk)
    begin
        if (drain)
        begin
            mem[pop_ent.addr[ADDR_W-1:0]] <= pop_ent.data;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    AST_DEV_NIBBLE: assert property (
        $rose(st_ff == ees_pkg::ST_DEV_ACK) |-> sh_ff[7:4] == ees_pkg::DEV_TYPE)
        else $error("Acknowledged a slave address with wrong type nibble");
    AST_ACK_DRIVES: assert property (
        st_ff == ees_pkg::ST_DEV_ACK && $past(st_ff) == ees_pkg::ST_DEV_ACK |-> !o_sda_oe_n)
        else $error("Address acknowledge slot not driven low");
    AST_BUSY_QUIET: assert property (
        busy_ff && $past(busy_ff) && $past(busy_ff, 2) |-> o_sda_oe_n)
        else $error("Data line driven during write cycle");
    AST_BUSY_NO_ADDR: assert property (
        busy_ff && start_ev |=> st_ff == ees_pkg::ST_IDLE)
        else $error("Address taken while write cycle runs");
    AST_PAGE_INC: assert property (
        pg_we |=> ptr_ff[ADDR_W-1:4] == $past(ptr_ff[ADDR_W-1:4])
                  && ptr_ff[3:0] == $past(ptr_ff[3:0]) + 4'h1)
        else $error("Write pointer left its page or missed increment");
    AST_WP_NACK: assert property (
        wp_lock_ff && byte_end && st_ff == ees_pkg::ST_WR
        |=> st_ff == ees_pkg::ST_SKIP && o_sda_oe_n [*2])
        else $error("Protected data byte was acknowledged");
    AST_RD_RELEASE: assert property (
        st_ff == ees_pkg::ST_RD_ACK && $past(st_ff) == ees_pkg::ST_RD_ACK |-> o_sda_oe_n)
        else $error("Data line held in master acknowledge slot");
    AST_STOP_IDLE: assert property (
        stop_ev |=> st_ff == ees_pkg::ST_IDLE && o_sda_oe_n)
        else $error("STOP did not return to standby");
    AST_NO_START: assert property (
        st_ff == ees_pkg::ST_IDLE && !start_ev |=> st_ff == ees_pkg::ST_IDLE)
        else $error("Left standby without START");
    AST_FALL_CHANGE: assert property (
        $changed(o_sda_oe_n) |-> $past(scl_fall || start_ev || stop_ev))
        else $error("Output changed outside a clock fall");
    AST_COMMIT_BUSY: assert property (
        commit |=> busy_ff ##1 busy_ff)
        else $error("Commit did not start write cycle");

    COV_PAGE_COMMIT: cover property (commit && pg_valid_ff == 16'hFFFF);
    COV_WP_REJECT: cover property (wp_lock_ff && byte_end && st_ff == ees_pkg::ST_WR);
    COV_SEQ_READ: cover property (st_ff == ees_pkg::ST_RD_ACK && scl_fall ##1 st_ff == ees_pkg::ST_RD);
    COV_WR_DONE: cover property (wr_done);
endmodule

// ---- logic/ees_pkg.sv ----
// Shared constants, types and states of the two-wire serial memory slave
package ees_pkg;
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          WR_TIME_MS     = 5;
    localparam int          NS_PER_MS      = 1_000_000;
    localparam int          MAX_ADDR_W     = 11;
    localparam int          PAGE_W         = 4;
    localparam int          PAGE_BYTES     = 16;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          DRAIN_DIV      = 4;
    localparam logic [3:0]  DEV_TYPE       = 4'hA;
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam logic [4:0]  PG_IDX_END     = 5'h10;
    localparam logic [10:0] PTR_RST        = 11'h000;

    typedef struct packed {
        logic [MAX_ADDR_W-1:0] addr;
        logic [7:0]            data;
    } ees_wr_s;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_MEM,
        ST_MEM_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_RD_ACK,
        ST_SKIP
    } ees_state_e;
endpackage

// ---- dv/ees_master.sv ----
// Two-wire bus master model that makes the clock and drives the data line
module ees_master (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Low 5 clocks then high 3: the slave's late drive settles before the rise
    task automatic bit_io(input logic b, output logic got);
        hold(1);
        o_sda = b;
        hold(4);
        o_scl = 1'b1;
        hold(3);
        got = i_sda;
        o_scl = 1'b0;
    endtask
    // Also serves as repeated start
    task automatic start();
        o_sda = 1'b1;
        hold(5);
        o_scl = 1'b1;
        hold(3);
        o_sda = 1'b0;
        hold(3);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        hold(5);
        o_scl = 1'b1;
        hold(3);
        o_sda = 1'b1;
        hold(3);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], g);
        bit_io(1'b1, g);
        ack = !g;
    endtask
    // Releasing on the last byte ends a read session
    task automatic rd_byte(input logic mack, output logic [7:0] d);
        logic g;
        for (int i = 0; i < 8; i++)
        begin
            bit_io(1'b1, g);
            d = {d[6:0], g};
        end
        bit_io(!mack, g);
    endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench of the two-wire memory slave against a byte array model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_clk, i_sys_rst, i_write_protect, o_sda, o_sda_oe_n, o_busy, scl, sda_m;
    logic [2:0] cs;
    logic [7:0] mem [2048];
    logic [10:0] a;
    int         ptr, n_mismatch, compares, cycles;
    int         seed = 32'h18b0_5d4f;
    wire logic  sda = sda_m & (o_sda_oe_n | o_sda);
    ees_master ees_master_inst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));
    // Mid density so that a select pin is compared and two upper bits still ride along
    ees_eeprom #(.ADDR_W(10), .WR_CYCLES(200)) ees_eeprom_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n), .i_write_protect(i_write_protect),
        .i_chip_select_pin_0(cs[0]), .i_chip_select_pin_1(cs[1]),
        .i_chip_select_pin_2(cs[2]), .o_busy(o_busy));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] d, input logic exp);
        logic ack;
        ees_master_inst.wr_byte(d, ack);
        chk(ack, exp);
    endtask
    // Select pin in bit 3, upper address bits below it
    function automatic logic [2:0] sel_bits(input logic [10:0] x);
        return {cs[2], x[9:8]};
    endfunction
    task automatic adr(input logic [3:0] nib, input logic [2:0] up, input logic rd,
                       input logic exp);
        ees_master_inst.start();
        send({nib, up, rd}, exp);
    endtask
    task automatic rd(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++)
        begin
            ees_master_inst.rd_byte(i < n - 1, d);
            chk(d, mem[ptr]);
            ptr = (ptr + 1) & 1023;
        end
        ees_master_inst.stop();
    endtask
    task automatic rnd_rd(input logic [10:0] a, input int n);
        adr(4'hA, sel_bits(a), 1'b0, 1'b1);
        send(a[7:0], 1'b1);
        ptr = a[9:0];
        adr(4'hA, sel_bits(11'h000), 1'b1, 1'b1);
        rd(n);
    endtask
    task automatic wr(input logic [10:0] a, input int n, input logic wp);
        logic [7:0] d;
        i_write_protect = wp;
        adr(4'hA, sel_bits(a), 1'b0, 1'b1);
        send(a[7:0], 1'b1);
        for (int i = 0; i < n; i++)
        begin
            d = 8'($random(seed));
            send(d, !wp);
            if (!wp)
                mem[{a[9:4], 4'(a[3:0] + i)}] = d;
        end
        ees_master_inst.stop();
        i_write_protect = 1'b0;
        if (!wp)
        begin
            chk(o_busy, 1'b1);
            adr(4'hA, sel_bits(11'h000), 1'b0, 1'b0);
            ees_master_inst.stop();
            for (int k = 0; k < 1000 && o_busy; k++)
                @(negedge i_clk);
            adr(4'hA, sel_bits(11'h000), 1'b0, 1'b1);
            ees_master_inst.stop();
        end
    endtask
    initial
    begin
        i_sys_rst = 1'b1;
        i_write_protect = 1'b0;
        cs = 3'($random(seed));
        foreach (mem[i])
            mem[i] = 8'hFF;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk({o_busy, o_sda_oe_n}, 8'h01);
        repeat (3) @(negedge i_clk);
        adr(4'hA, sel_bits(11'h000), 1'b1, 1'b1);
        rd(3);
        $display("test immediate read done");
        adr(4'hB, 3'h0, 1'b0, 1'b0);
        ees_master_inst.stop();
        adr(4'hA, {~cs[2], 2'h0}, 1'b0, 1'b0);
        ees_master_inst.stop();
        $display("test foreign address done");
        a = 11'($random(seed));
        wr(a, 18, 1'b0);
        rnd_rd({a[10:4], 4'h0}, 16);
        adr(4'hA, sel_bits(11'h000), 1'b1, 1'b1);
        rd(2);
        $display("test page write done");
        cs = 3'($random(seed));
        a = 11'($random(seed));
        wr(a, 1, 1'b1);
        rnd_rd(a, 1);
        $display("test protected write done");
        a = 11'($random(seed));
        wr(a, 1, 1'b0);
        rnd_rd(a, 1);
        rnd_rd(11'h3FE, 3);
        $display("test byte write and wrap done");
        close_out();
    end
endmodule
